// ### hw/crd_params.svh
/*
 * Constants for the card reader status logic: bit positions of the
 * status word, register selects and the reset values of flag and status state.
 * Assumes nothing; definitions only.
 */
`ifndef CRD_PARAMS_SVH
`define CRD_PARAMS_SVH

// Register selects on the documented three-address port
`define SEL_STATUS 2'h0
`define SEL_BUF_RAW 2'h1
`define SEL_BUF_PACKED 2'h2

// Status bit positions
`define BIT_ERROR 15
`define BIT_CARD_DONE 14
`define BIT_TRAY 13
`define BIT_TRANSPORT 12
`define BIT_OVERRUN 11
`define BIT_ONLINE_EV 10
`define BIT_BUSY 9
`define BIT_OFFLINE 8
`define BIT_COL_AVAIL 7
`define BIT_IE 6
`define BIT_DISCARD 1
`define BIT_READ 0

// Reset values of control and flag state
`define RST_FLAG 1'h0
`define RST_STATUS 16'h0000

`endif

// ### hw/crd_pkg.sv
/*
 * Types shared by the card reader status logic.
 * Assumes crd_params.svh is on the include path.
 */
package crd_pkg;

   // Bus request toward the registers
   typedef struct packed {
      logic rd;           // Read strobe, one cycle
      logic wr;           // Write strobe, one cycle
      logic [1:0] sel;    // Register select
      logic [1:0] be;     // Byte enables, bit 0 low byte
      logic [15:0] wdata; // Write data
   } bus_req_t;

   // Sensor inputs from the reader mechanism
   typedef struct packed {
      logic online;       // Reader on-line level
      logic tray_alarm;   // Hopper empty or stacker full
      logic feed_fail;    // Feed failure
      logic jam;          // Card jam
      logic stack_fail;   // Stacking failure
      logic card_in_stn;  // Card in read station
      logic col_strobe;   // New column latched, one-cycle pulse
      logic card_end;     // Card left the read station, pulse
      logic [11:0] col;   // Column data
   } sensor_t;

   // Read state
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_FEED = 2'b01,
      RD_DONE = 2'b10
   } rd_state_t;

endpackage

// ### hw/crd_flag.sv
/*
 * One sticky flag: set wins over clear, synchronous clear, async reset.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "crd_params.svh"

module crd_flag (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Controls
   input wire logic set,
   input wire logic clr,
   // State
   output logic q
);
   logic flag_ff; // Stored flag
   logic nxt_flag; // Next value

   // Set takes priority so no event is lost
   always_comb begin
      nxt_flag = flag_ff;
      if (clr) begin
         nxt_flag = 1'b0;
      end
      if (set) begin
         nxt_flag = 1'b1;
      end
   end

   // Register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= `RST_FLAG;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign q = flag_ff;
endmodule
`default_nettype wire

// ### hw/crd_status.sv
/*
 * Card reader status register logic: error, card done, tray alarm,
 * transport fault, column overrun, went-online, busy, off-line and
 * column-available flags, with a word-wide register port.
 * Assumes synchronous sensor inputs and one-cycle bus strobes.
 */
//
// Function
// - Going off-line sets error flip-flop
// - Overrun at card end sets error
// - Read ignored while error set and its cause persists
// - Error read-only, init clears, interrupts
// - Status write clears four flags when clean
// - High-byte-only status writes do nothing
// - Card done sets after card passes
// - Bit 13 shows tray alarm live
// - Bit 12 shows transport faults live
// - Missing sensor strapped to read zero
// - Column overrun when buffer unread
// - Overrun clears column available
// - Overrun blocks column available, transfers
// - Discard bit never blocks overrun setting
// - Went-online sets on coming on-line with no tray or transport fault
// - Busy while card read in station
// - Bit 8 shows off-line state
// - Column available sets on new column
// - Buffer access clears column available
// - Discard or overrun inhibits column available
// - Overrun still flagged after discard
// - Interrupt needs enable and a source
// - Unused bits zero, read-only unchanged
`timescale 1ns/1ps
`default_nettype none
`include "crd_params.svh"

module crd_status (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // Processor bus
   input wire crd_pkg::bus_req_t BUS_REQ,
   input wire logic BUS_INIT,
   output logic [15:0] BUS_RDATA,
   // Reader mechanism
   input wire crd_pkg::sensor_t SENSE,
   input wire logic TRAY_FITTED,
   input wire logic TRANSPORT_FITTED,
   output logic READ_CMD,
   // Interrupt request
   output logic IRQ
);
   import crd_pkg::*;

   // ****************************************************************
   // Decode
   // ****************************************************************
   logic st_wr; // Status write that touches the low byte
   logic buf_acc; // Any access to either buffer address
   logic tray_bit; // Strapped tray alarm
   logic xport_bit; // Strapped transport fault
   logic cause; // Some error cause remains

   assign st_wr = BUS_REQ.wr && (BUS_REQ.sel == `SEL_STATUS) && BUS_REQ.be[0];
   assign buf_acc = (BUS_REQ.rd || BUS_REQ.wr) &&
                    ((BUS_REQ.sel == `SEL_BUF_RAW) ||
                     (BUS_REQ.sel == `SEL_BUF_PACKED));
   assign tray_bit = TRAY_FITTED && SENSE.tray_alarm;
   assign xport_bit = TRANSPORT_FITTED &&
                      (SENSE.feed_fail || SENSE.jam || SENSE.stack_fail);
   assign cause = tray_bit || xport_bit || !SENSE.online;

   // ****************************************************************
   // Control bits and line tracking
   // ****************************************************************
   logic ie_ff, nxt_ie; // Interrupt enable
   logic disc_ff, nxt_disc; // Discard-card command
   logic read_ff, nxt_read; // Read command
   logic online_ff, nxt_online; // Previous on-line level
   logic [11:0] buf_ff, nxt_buf; // Column data buffer
   rd_state_t rst_ff, nxt_rst; // Read state

   logic err_q, done_q, ovr_q, onl_q, cav_q;
   logic clr_write; // Flag clear by status write

   assign clr_write = st_wr && !cause;

   // Next values of control state
   always_comb begin
      nxt_ie = ie_ff;
      nxt_disc = disc_ff;
      nxt_read = read_ff;
      nxt_online = SENSE.online;
      nxt_buf = buf_ff;
      nxt_rst = rst_ff;
      if (st_wr) begin
         nxt_ie = BUS_REQ.wdata[`BIT_IE];
         nxt_disc = BUS_REQ.wdata[`BIT_DISCARD];
         if (BUS_REQ.wdata[`BIT_READ] && !(err_q && cause)) begin
            nxt_read = 1'b1;
         end
      end
      if (SENSE.col_strobe && !ovr_q) begin
         nxt_buf = SENSE.col;
      end
      case (rst_ff)
         RD_IDLE: begin
            if (read_ff && SENSE.card_in_stn) begin
               nxt_rst = RD_FEED;
            end
         end
         RD_FEED: begin
            // busy ends with card or command
            if (SENSE.card_end || !SENSE.card_in_stn || !read_ff) begin
               nxt_rst = RD_DONE;
            end
         end
         RD_DONE: begin
            nxt_read = 1'b0;
            nxt_rst = RD_IDLE;
         end
         default: begin
            nxt_rst = RD_IDLE;
         end
      endcase
      if (!SENSE.online) begin
         nxt_read = 1'b0;
      end
      if (BUS_INIT) begin
         nxt_ie = 1'b0;
         nxt_disc = 1'b0;
         nxt_read = 1'b0;
         nxt_rst = RD_IDLE;
      end
   end

   // Register control state
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ie_ff <= `RST_FLAG;
         disc_ff <= `RST_FLAG;
         read_ff <= `RST_FLAG;
         online_ff <= `RST_FLAG;
         buf_ff <= 12'h000;
         rst_ff <= RD_IDLE;
      end else begin
         ie_ff <= nxt_ie;
         disc_ff <= nxt_disc;
         read_ff <= nxt_read;
         online_ff <= nxt_online;
         buf_ff <= nxt_buf;
         rst_ff <= nxt_rst;
      end
   end

   // ****************************************************************
   // Sticky flags
   // ****************************************************************
   logic err_set, done_set, ovr_set, onl_set, cav_set, cav_clr;
   logic overrun_now; // New column while previous unread

   assign overrun_now = SENSE.col_strobe && cav_q;
   assign ovr_set = overrun_now && !(disc_ff && !cav_q);
   // off-line edge, overrun at card end
   assign err_set = (online_ff && !SENSE.online) ||
                    (SENSE.card_end && (ovr_q || ovr_set));
   assign done_set = SENSE.card_end;
   assign onl_set = !online_ff && SENSE.online && !cause;
   assign cav_set = SENSE.col_strobe && !cav_q && !ovr_q && !disc_ff;
   assign cav_clr = buf_acc || ovr_set || BUS_INIT;

   crd_flag u_err (
      .clk(CORE_CLK), .rst_n(RST_N), .set(err_set),
      .clr(BUS_INIT || clr_write), .q(err_q));
   crd_flag u_done (
      .clk(CORE_CLK), .rst_n(RST_N), .set(done_set),
      .clr(BUS_INIT || clr_write), .q(done_q));
   crd_flag u_ovr (
      .clk(CORE_CLK), .rst_n(RST_N), .set(ovr_set),
      .clr(BUS_INIT || clr_write), .q(ovr_q));
   crd_flag u_onl (
      .clk(CORE_CLK), .rst_n(RST_N), .set(onl_set),
      .clr(BUS_INIT || clr_write), .q(onl_q));
   crd_flag u_cav (
      .clk(CORE_CLK), .rst_n(RST_N), .set(cav_set),
      .clr(cav_clr), .q(cav_q));

   // ****************************************************************
   // Read data and outputs
   // ****************************************************************
   logic [15:0] status_w; // Assembled status word
   logic [15:0] rdata_ff, nxt_rdata; // Registered read data
   logic irq_ff, nxt_irq; // Registered interrupt

   always_comb begin
      status_w = `RST_STATUS;
      status_w[`BIT_ERROR] = err_q;
      status_w[`BIT_CARD_DONE] = done_q;
      status_w[`BIT_TRAY] = tray_bit;
      status_w[`BIT_TRANSPORT] = xport_bit;
      status_w[`BIT_OVERRUN] = ovr_q;
      status_w[`BIT_ONLINE_EV] = onl_q;
      status_w[`BIT_BUSY] = (rst_ff == RD_FEED);
      status_w[`BIT_OFFLINE] = !SENSE.online;
      status_w[`BIT_COL_AVAIL] = cav_q;
      status_w[`BIT_IE] = ie_ff;
      status_w[`BIT_DISCARD] = disc_ff;
      status_w[`BIT_READ] = read_ff;
   end

   // Read mux and interrupt request
   always_comb begin
      nxt_rdata = rdata_ff;
      if (BUS_REQ.rd) begin
         case (BUS_REQ.sel)
            `SEL_STATUS: nxt_rdata = status_w;
            `SEL_BUF_RAW: nxt_rdata = {4'h0, buf_ff};
            `SEL_BUF_PACKED: nxt_rdata = {8'h00, buf_ff[7:0]};
            default: nxt_rdata = 16'h0000;
         endcase
      end
      nxt_irq = ie_ff && (err_q || done_q || onl_q || cav_q);
   end

   // Register outputs
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_ff <= `RST_STATUS;
         irq_ff <= `RST_FLAG;
      end else begin
         rdata_ff <= nxt_rdata;
         irq_ff <= nxt_irq;
      end
   end

   assign BUS_RDATA = rdata_ff;
   assign IRQ = irq_ff;
   assign READ_CMD = read_ff;
endmodule
`default_nettype wire

// ### tb/crd_status_chk.sv
/* Port checker for the card reader status logic.
   Assumes it is bound to crd_status and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module crd_status_chk (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // Bus and reader side
   input wire crd_pkg::bus_req_t BUS_REQ,
   input wire logic BUS_INIT,
   input wire logic [15:0] BUS_RDATA,
   input wire crd_pkg::sensor_t SENSE,
   input wire logic TRAY_FITTED,
   input wire logic TRANSPORT_FITTED,
   input wire logic READ_CMD,
   input wire logic IRQ
);
   import crd_pkg::*;
   default clocking dc @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // Status read strobe
   wire logic rs = BUS_REQ.rd && BUS_REQ.sel == 2'h0;
   unused_zero_a: assert property (rs |=> BUS_RDATA[5:2] == 4'h0)
      else $error("unused status bits not zero");
   unmapped_zero_a: assert property (BUS_REQ.rd && BUS_REQ.sel == 2'h3
      |=> BUS_RDATA == 16'h0000) else $error("unmapped read not zero");
   tray_live_a: assert property (rs && TRAY_FITTED &&
      $stable(SENSE.tray_alarm) && $stable(TRAY_FITTED)
      |=> BUS_RDATA[13] == $past(SENSE.tray_alarm))
      else $error("tray bit wrong");
   strap_off_a: assert property (rs && !TRANSPORT_FITTED &&
      !$past(TRANSPORT_FITTED) |=> !BUS_RDATA[12])
      else $error("strapped bit not zero");
   offline_bit_a: assert property (rs && $stable(SENSE.online)
      |=> BUS_RDATA[8] == !$past(SENSE.online))
      else $error("offline bit wrong");
   init_irq_a: assert property (BUS_INIT ##1 !BUS_REQ.wr |=> !IRQ)
      else $error("interrupt after init");
   ie_write_a: assert property (BUS_REQ.wr && BUS_REQ.sel == 2'h0 &&
      BUS_REQ.be[0] && !BUS_INIT ##1 rs && !BUS_REQ.wr && !BUS_INIT
      |=> BUS_RDATA[6] == $past(BUS_REQ.wdata[6], 2))
      else $error("enable bit not written");
   buf_clear_a: assert property (BUS_REQ.rd && BUS_REQ.sel == 2'h1 &&
      !SENSE.col_strobe ##1 rs && !SENSE.col_strobe |=> !BUS_RDATA[7])
      else $error("column flag not cleared");
   cover property (rs ##1 BUS_RDATA[11]);
   cover property (rs ##1 BUS_RDATA[15]);
   cover property (IRQ);
endmodule
bind crd_status crd_status_chk i_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
   .BUS_REQ(BUS_REQ), .BUS_INIT(BUS_INIT), .BUS_RDATA(BUS_RDATA),
   .SENSE(SENSE), .TRAY_FITTED(TRAY_FITTED),
   .TRANSPORT_FITTED(TRANSPORT_FITTED), .READ_CMD(READ_CMD), .IRQ(IRQ));
`default_nettype wire

// ### tb/crd_reader_model.sv
/* Reader mechanism model: sensor levels, column and card pulses.
   Assumes bench commands change just after the rising edge. */
`timescale 1ns/1ps
`default_nettype none
module crd_reader_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bench commands: online, tray, feed, jam, stack
   input wire logic [4:0] lvl,
   input wire logic col_go,
   input wire logic end_go,
   input wire logic [11:0] col_val,
   // Controller side
   input wire logic read_cmd,
   output crd_pkg::sensor_t sense
);
   import crd_pkg::*;
   sensor_t sense_ff;
   sensor_t nxt_sense;
   assign sense = sense_ff;
   // Card enters on a read command and leaves at card end
   always_comb begin
      nxt_sense = sense_ff;
      {nxt_sense.online, nxt_sense.tray_alarm, nxt_sense.feed_fail,
         nxt_sense.jam, nxt_sense.stack_fail} = lvl;
      nxt_sense.col_strobe = col_go;
      nxt_sense.card_end = end_go;
      // Column lines carry data only with the strobe
      nxt_sense.col = col_go ? col_val : ~sense_ff.col;
      if (end_go) begin
         nxt_sense.card_in_stn = 1'h0;
      end else if (read_cmd && lvl[4]) begin
         nxt_sense.card_in_stn = 1'h1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sense_ff <= '0;
      end else begin
         sense_ff <= nxt_sense;
      end
   end
endmodule
`default_nettype wire

// ### tb/tb_crd_status.sv
/* Self-checking bench for the card reader status logic.
   Assumes the design package and the reader model are compiled. */
`timescale 1ns/1ps
`default_nettype none
module tb_crd_status;
   import crd_pkg::*;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   bus_req_t req = '0;
   logic init = 1'h0;
   logic tray_fit = 1'h1;
   logic tr_fit = 1'h1;
   logic [4:0] lvl = 5'h00;
   logic col_go = 1'h0;
   logic end_go = 1'h0;
   logic [11:0] col_val = 12'h000;
   logic [15:0] rdata;
   sensor_t sense;
   logic read_cmd;
   logic irq;
   integer seed = 32'h4b921cc0;
   integer bad_count = 0;
   integer n_compared = 0;
   logic [11:0] v;
   crd_status i_crd_status (.CORE_CLK(clk), .RST_N(rst_n), .BUS_REQ(req),
      .BUS_INIT(init), .BUS_RDATA(rdata), .SENSE(sense),
      .TRAY_FITTED(tray_fit), .TRANSPORT_FITTED(tr_fit),
      .READ_CMD(read_cmd), .IRQ(irq));
   crd_reader_model i_crd_reader_model (.clk(clk), .rst_n(rst_n),
      .lvl(lvl), .col_go(col_go), .end_go(end_go), .col_val(col_val),
      .read_cmd(read_cmd), .sense(sense));
   initial begin
      forever #25 clk = ~clk;
   end
   // Raw buffer word for a column
   function automatic logic [15:0] raw_exp(input logic [11:0] c);
      return {4'h0, c};
   endfunction
   task automatic chk(input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t: exp %h got %h", $time, e, g);
      end
   endtask
   // One bus cycle; read data settled on return
   task automatic bus(input logic r, input logic [1:0] s,
      input logic [1:0] b, input logic [15:0] d);
      @(posedge clk);
      req <= '{rd: r, wr: !r, sel: s, be: b, wdata: d};
      @(posedge clk);
      req.rd <= 1'h0;
      req.wr <= 1'h0;
      #1;
   endtask
   task automatic st(input logic [15:0] e);
      bus(1'h1, 2'h0, 2'h3, 16'h0000);
      chk(e, rdata);
   endtask
   task automatic wr(input logic [15:0] d);
      bus(1'h0, 2'h0, 2'h3, d);
   endtask
   // Column strobe (c=1) or card end (c=0) from the reader
   task automatic pulse(input logic c, input logic [11:0] x);
      @(posedge clk);
      col_go <= c;
      end_go <= !c;
      col_val <= x;
      @(posedge clk);
      col_go <= 1'h0;
      end_go <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic lv(input logic [4:0] x);
      lvl <= x;
      repeat (4) @(posedge clk);
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      report_and_stop;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      st(16'h0100);
      bus(1'h1, 2'h3, 2'h3, 16'h0000);
      chk(16'h0000, rdata);
      lv(5'h10);
      st(16'h0400);
      wr(16'hFFC0);
      st(16'h0040);
      // Write then status read back to back, no idle cycle between
      @(posedge clk);
      req <= '{rd: 1'h0, wr: 1'h1, sel: 2'h0, be: 2'h1, wdata: 16'h0040};
      @(posedge clk);
      req <= '{rd: 1'h1, wr: 1'h0, sel: 2'h0, be: 2'h3, wdata: 16'h0000};
      @(posedge clk);
      req.rd <= 1'h0;
      #1;
      chk(16'h0040, rdata);
      for (int i = 0; i < 6; i++) begin
         v = 12'($random(seed));
         pulse(1'h1, v);
         chk(16'h0001, {15'h0, irq});
         bus(1'h0, 2'h0, 2'h2, 16'h0000);
         st(16'h00C0);
         // Reading the buffer before the next column
         bus(1'h1, {i[0], !i[0]}, 2'h3, 16'h0000);
         if (!i[0]) chk(raw_exp(v), rdata);
         else chk({8'h00, v[7:0]}, rdata);
         st(16'h0040);
      end
      pulse(1'h1, 12'h001);
      pulse(1'h1, 12'h002);
      st(16'h0840);
      pulse(1'h1, 12'h003);
      st(16'h0840);
      pulse(1'h0, 12'h000);
      st(16'hC840);
      wr(16'h0040);
      st(16'h0040);
      wr(16'h0042);
      pulse(1'h1, 12'h004);
      st(16'h0042);
      wr(16'h0040);
      pulse(1'h1, 12'h005);
      wr(16'h0042);
      pulse(1'h1, 12'h006);
      st(16'h0842);
      wr(16'h0041);
      repeat (3) @(posedge clk);
      st(16'h0241);
      pulse(1'h0, 12'h000);
      st(16'h4040);
      chk(16'h0001, {15'h0, irq});
      wr(16'h0040);
      lv(5'h00);
      st(16'h8140);
      wr(16'h0041);
      st(16'h8140);
      chk(16'h0000, {15'h0, read_cmd});
      lv(5'h0F);
      st(16'hB140);
      tray_fit <= 1'h0;
      tr_fit <= 1'h0;
      st(16'h8140);
      tray_fit <= 1'h1;
      tr_fit <= 1'h1;
      lv(5'h00);
      init <= 1'h1;
      @(posedge clk);
      init <= 1'h0;
      st(16'h0100);
      chk(16'h0000, {15'h0, irq});
      report_and_stop;
   end
endmodule
`default_nettype wire
